// ===== design/fetch_flag_nmi_emulation_ports.v
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "pin_mux_consts.vh"

//Contract
// - Fetch flag only meaningful during an external bus cycle.
// - Fetch flag high for entire external instruction-fetch cycle.
// - Fetch flag low for data, vector and configuration byte accesses.
// - Fetch flag low for fetches served from internal memory.
// - In normal mode a rising NMI edge raises a nonmaskable interrupt.
// - NMI outranks every other prioritized interrupt source.
// - Strap low at reset rise enters emulation; PLL strap also low.
// - Emulation strap captured when reset returns inactive.
// - In emulation mode every pin is high impedance.
// - Emulation mode left only through a new reset.
// - Compare-only outputs share pins with general port nine.
// - Port two is 8-bit bidirectional, per-pin function select.
// - Port two carries serial lines, external irq, strap, clock out.
// - Ports three, four: 8-bit, open-drain or complementary drive.
// - Address/data bus use forces complementary drive.
// - Port three shares pins with address/data bits 7..0.
// - Port four shares pins with address/data bits 15..8.
// - External-access strap latched at reset rise only.
module fetch_flag_nmi_emulation_ports #(
	parameter STATE_CLKS = `STATE_CLKS
)(
	// Clock, reset, enable
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Straps and interrupt pins
	input  wire        emulation_isolate_strap_n,
	input  wire        pll_enable_strap,
	input  wire        external_access_strap_n,
	input  wire        nmi_pin,
	// Core bus status
	input  wire        bus_cycle_active,
	input  wire        bus_cycle_fetch,
	input  wire        bus_cycle_internal,
	input  wire        bus_addr_data_low,
	input  wire        bus_addr_data_high,
	input  wire [15:0] bus_ad_out,
	input  wire        bus_ad_drive,
	input  wire        other_irq_req,
	// Peripheral functions
	input  wire        serial0_transmit,
	input  wire        serial1_transmit,
	input  wire        clkout_func,
	input  wire [7:0]  compare_only_outputs,
	output reg         serial0_receive,
	output reg         serial1_receive,
	output reg         external_irq_in,
	output reg  [15:0] bus_ad_in,
	output reg         nmi_event,
	output reg         irq_grant_nmi,
	output reg         irq_grant_other,
	output reg         onchip_emulation_mode,
	output reg         external_access_latched_n,
	// Fetch flag pin
	output reg         instr_fetch_flag,
	output reg         instr_fetch_flag_oe,
	// Port two pins
	input  wire [7:0]  port_two_pins_in,
	output reg  [7:0]  port_two_pins_out,
	output reg  [7:0]  port_two_pins_oe,
	// Port three pins
	input  wire [7:0]  port_three_pins_in,
	output reg  [7:0]  port_three_pins_out,
	output reg  [7:0]  port_three_pins_oe,
	// Port four pins
	input  wire [7:0]  port_four_pins_in,
	output reg  [7:0]  port_four_pins_out,
	output reg  [7:0]  port_four_pins_oe,
	// Port nine pins
	input  wire [7:0]  port_nine_pins_in,
	output reg  [7:0]  port_nine_pins_out,
	output reg  [7:0]  port_nine_pins_oe
);

////////////////////////////////////////////////////////////////////////////////
// Registers and synchronisers

reg  [7:0] p2_out_r, p2_dir_r, p2_sel_r;
reg  [7:0] p3_out_r, p3_dir_r, p3_od_r;
reg  [7:0] p4_out_r, p4_dir_r, p4_od_r;
reg  [7:0] p9_out_r, p9_dir_r, p9_sel_r;
reg        strap_done_r;
reg        nmi_prev_r;
reg        nmi_pend_r;
reg  [3:0] st_cnt_r;
wire [7:0] p2_s, p3_s, p4_s, p9_s;
wire       nmi_s;

sync2 #(.W(33)) u_sync (
	.pclk    (pclk),
	.presetn (presetn),
	.ce      (ce),
	.d       ({nmi_pin, port_nine_pins_in, port_four_pins_in,
	           port_three_pins_in, port_two_pins_in}),
	.q       ({nmi_s, p9_s, p4_s, p3_s, p2_s})
);

////////////////////////////////////////////////////////////////////////////////
// Strap capture at reset release

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		strap_done_r              <= 1'b0;
		onchip_emulation_mode     <= 1'b0;
		external_access_latched_n <= 1'b1;
	end
	else if (!strap_done_r)
	begin
		strap_done_r              <= 1'b1;
		onchip_emulation_mode     <= ~emulation_isolate_strap_n & ~pll_enable_strap;
		external_access_latched_n <= external_access_strap_n;
	end
end
// Pins stay released until the straps are known
wire pins_off = onchip_emulation_mode | ~strap_done_r;

////////////////////////////////////////////////////////////////////////////////
// NMI edge detection at state-time resolution

wire st_tick = (st_cnt_r == STATE_CLKS[3:0] - 4'h1);
wire nmi_rise = st_tick & nmi_s & ~nmi_prev_r;

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		st_cnt_r        <= 4'h0;
		nmi_prev_r      <= 1'b0;
		nmi_pend_r      <= 1'b0;
		nmi_event       <= 1'b0;
		irq_grant_nmi   <= 1'b0;
		irq_grant_other <= 1'b0;
	end
	else if (ce)
	begin
		st_cnt_r  <= st_tick ? 4'h0 : st_cnt_r + 4'h1;
		if (st_tick)
			nmi_prev_r <= nmi_s;
		nmi_event <= nmi_rise & ~onchip_emulation_mode;
		// Pending set wins over the grant clear
		if (nmi_rise & ~onchip_emulation_mode)
			nmi_pend_r <= 1'b1;
		else if (nmi_pend_r)
			nmi_pend_r <= 1'b0;
		irq_grant_nmi   <= nmi_pend_r;
		irq_grant_other <= other_irq_req & ~nmi_pend_r & ~nmi_rise;
	end
end

////////////////////////////////////////////////////////////////////////////////
// APB slave

wire apb_wr = psel & penable & pwrite & ~pready;
wire apb_rd = psel & penable & ~pwrite & ~pready;
reg  [31:0] rd_nxt;
reg         hit_nxt;

always @*
begin
	rd_nxt  = `RST_WORD;
	hit_nxt = 1'b1;
	case (paddr)
		`REG_P2_OUT: rd_nxt[7:0] = p2_out_r;
		`REG_P2_DIR: rd_nxt[7:0] = p2_dir_r;
		`REG_P2_SEL: rd_nxt[7:0] = p2_sel_r;
		`REG_P3_OUT: rd_nxt[7:0] = p3_out_r;
		`REG_P3_DIR: rd_nxt[7:0] = p3_dir_r;
		`REG_P3_OD:  rd_nxt[7:0] = p3_od_r;
		`REG_P4_OUT: rd_nxt[7:0] = p4_out_r;
		`REG_P4_DIR: rd_nxt[7:0] = p4_dir_r;
		`REG_P4_OD:  rd_nxt[7:0] = p4_od_r;
		`REG_P9_OUT: rd_nxt[7:0] = p9_out_r;
		`REG_P9_DIR: rd_nxt[7:0] = p9_dir_r;
		`REG_P9_SEL: rd_nxt[7:0] = p9_sel_r;
		`REG_PIN_IN: rd_nxt      = {8'h00, p4_s, p3_s, p2_s};
		`REG_P9_IN:  rd_nxt[7:0] = p9_s;
		`REG_STATUS:
		begin
			rd_nxt[`ST_EMU_BIT]    = onchip_emulation_mode;
			rd_nxt[`ST_EXTACC_BIT] = external_access_latched_n;
			rd_nxt[`ST_NMI_BIT]    = nmi_pend_r;
		end
		default:     hit_nxt = 1'b0;
	endcase
end

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		pready   <= 1'b0;
		pslverr  <= 1'b0;
		prdata   <= `RST_WORD;
		p2_out_r <= `RST_BYTE;
		p2_dir_r <= `RST_BYTE;
		p2_sel_r <= `RST_BYTE;
		p3_out_r <= `RST_BYTE;
		p3_dir_r <= `RST_BYTE;
		p3_od_r  <= `RST_BYTE;
		p4_out_r <= `RST_BYTE;
		p4_dir_r <= `RST_BYTE;
		p4_od_r  <= `RST_BYTE;
		p9_out_r <= `RST_BYTE;
		p9_dir_r <= `RST_BYTE;
		p9_sel_r <= `RST_BYTE;
	end
	else if (ce)
	begin
		pready  <= psel & penable & ~pready;
		pslverr <= psel & penable & ~pready & ~hit_nxt;
		if (apb_rd)
			prdata <= rd_nxt;
		if (apb_wr)
		begin
			case (paddr)
				`REG_P2_OUT: p2_out_r <= pwdata[7:0];
				`REG_P2_DIR: p2_dir_r <= pwdata[7:0];
				`REG_P2_SEL: p2_sel_r <= pwdata[7:0];
				`REG_P3_OUT: p3_out_r <= pwdata[7:0];
				`REG_P3_DIR: p3_dir_r <= pwdata[7:0];
				`REG_P3_OD:  p3_od_r  <= pwdata[7:0];
				`REG_P4_OUT: p4_out_r <= pwdata[7:0];
				`REG_P4_DIR: p4_dir_r <= pwdata[7:0];
				`REG_P4_OD:  p4_od_r  <= pwdata[7:0];
				`REG_P9_OUT: p9_out_r <= pwdata[7:0];
				`REG_P9_DIR: p9_dir_r <= pwdata[7:0];
				`REG_P9_SEL: p9_sel_r <= pwdata[7:0];
				default:     p2_out_r <= p2_out_r;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Pin multiplexing

reg  [7:0] p2_fn_out, p2_fn_oe;
reg  [7:0] p3_o_nxt, p3_e_nxt, p4_o_nxt, p4_e_nxt, p9_o_nxt, p9_e_nxt;
reg        fetch_nxt;

always @*
begin
	// Port two per-pin special functions
	p2_fn_out = p2_out_r;
	p2_fn_oe  = p2_dir_r;
	if (p2_sel_r[`P2_SERIAL0_TRANSMIT_BIT])
	begin
		p2_fn_out[`P2_SERIAL0_TRANSMIT_BIT] = serial0_transmit;
		p2_fn_oe[`P2_SERIAL0_TRANSMIT_BIT]  = 1'b1;
	end
	if (p2_sel_r[`P2_SERIAL0_RECEIVE_BIT])
		p2_fn_oe[`P2_SERIAL0_RECEIVE_BIT] = 1'b0;
	if (p2_sel_r[`P2_EXTERNAL_IRQ_IN_BIT])
		p2_fn_oe[`P2_EXTERNAL_IRQ_IN_BIT] = 1'b0;
	if (p2_sel_r[`P2_SERIAL1_TRANSMIT_BIT])
	begin
		p2_fn_out[`P2_SERIAL1_TRANSMIT_BIT] = serial1_transmit;
		p2_fn_oe[`P2_SERIAL1_TRANSMIT_BIT]  = 1'b1;
	end
	if (p2_sel_r[`P2_SERIAL1_RECEIVE_BIT])
		p2_fn_oe[`P2_SERIAL1_RECEIVE_BIT] = 1'b0;
	if (p2_sel_r[`P2_STRAP_BIT])
		p2_fn_oe[`P2_STRAP_BIT] = 1'b0;
	if (p2_sel_r[`P2_CLKOUT_BIT])
	begin
		p2_fn_out[`P2_CLKOUT_BIT] = clkout_func;
		p2_fn_oe[`P2_CLKOUT_BIT]  = 1'b1;
	end
	// Port three: bus wins, complementary drive
	if (bus_addr_data_low)
	begin
		p3_o_nxt = bus_ad_out[7:0];
		p3_e_nxt = {8{bus_ad_drive}};
	end
	else
	begin
		p3_o_nxt = p3_out_r & ~p3_od_r;
		p3_e_nxt = p3_dir_r & ~(p3_od_r & p3_out_r);
	end
	// Port four: bus wins, complementary drive
	if (bus_addr_data_high)
	begin
		p4_o_nxt = bus_ad_out[15:8];
		p4_e_nxt = {8{bus_ad_drive}};
	end
	else
	begin
		p4_o_nxt = p4_out_r & ~p4_od_r;
		p4_e_nxt = p4_dir_r & ~(p4_od_r & p4_out_r);
	end
	// Port nine or compare-only outputs
	p9_o_nxt = (p9_sel_r & compare_only_outputs) | (~p9_sel_r & p9_out_r);
	p9_e_nxt = p9_sel_r | p9_dir_r;
	// Fetch flag
	fetch_nxt = bus_cycle_active & bus_cycle_fetch & ~bus_cycle_internal;
end

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		port_two_pins_out   <= `RST_BYTE;
		port_two_pins_oe    <= `RST_BYTE;
		port_three_pins_out <= `RST_BYTE;
		port_three_pins_oe  <= `RST_BYTE;
		port_four_pins_out  <= `RST_BYTE;
		port_four_pins_oe   <= `RST_BYTE;
		port_nine_pins_out  <= `RST_BYTE;
		port_nine_pins_oe   <= `RST_BYTE;
		instr_fetch_flag    <= 1'b0;
		instr_fetch_flag_oe <= 1'b0;
		bus_ad_in           <= 16'h0000;
		serial0_receive     <= 1'b1;
		serial1_receive     <= 1'b1;
		external_irq_in     <= 1'b0;
	end
	else if (ce)
	begin
		port_two_pins_out   <= p2_fn_out;
		port_three_pins_out <= p3_o_nxt;
		port_four_pins_out  <= p4_o_nxt;
		port_nine_pins_out  <= p9_o_nxt;
		instr_fetch_flag    <= fetch_nxt;
		// Emulation isolates every pin
		port_two_pins_oe    <= pins_off ? `RST_BYTE : p2_fn_oe;
		port_three_pins_oe  <= pins_off ? `RST_BYTE : p3_e_nxt;
		port_four_pins_oe   <= pins_off ? `RST_BYTE : p4_e_nxt;
		port_nine_pins_oe   <= pins_off ? `RST_BYTE : p9_e_nxt;
		instr_fetch_flag_oe <= strap_done_r & ~onchip_emulation_mode;
		bus_ad_in           <= {p4_s, p3_s};
		serial0_receive     <= p2_sel_r[`P2_SERIAL0_RECEIVE_BIT] ? p2_s[`P2_SERIAL0_RECEIVE_BIT] : 1'b1;
		serial1_receive     <= p2_sel_r[`P2_SERIAL1_RECEIVE_BIT] ? p2_s[`P2_SERIAL1_RECEIVE_BIT] : 1'b1;
		external_irq_in     <= p2_sel_r[`P2_EXTERNAL_IRQ_IN_BIT] & p2_s[`P2_EXTERNAL_IRQ_IN_BIT];
	end
end

endmodule

// ===== pkg/pin_mux_consts.vh
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH

// Register byte addresses
`define REG_P2_OUT      12'h000
`define REG_P2_DIR      12'h004
`define REG_P2_SEL      12'h008
`define REG_P3_OUT      12'h00C
`define REG_P3_DIR      12'h010
`define REG_P3_OD       12'h014
`define REG_P4_OUT      12'h018
`define REG_P4_DIR      12'h01C
`define REG_P4_OD       12'h020
`define REG_P9_OUT      12'h024
`define REG_P9_DIR      12'h028
`define REG_P9_SEL      12'h02C
`define REG_PIN_IN      12'h030
`define REG_STATUS      12'h034
`define REG_P9_IN       12'h038

// Port two pin positions
`define P2_SERIAL0_TRANSMIT_BIT     0
`define P2_SERIAL0_RECEIVE_BIT     1
`define P2_EXTERNAL_IRQ_IN_BIT   2
`define P2_SERIAL1_TRANSMIT_BIT     3
`define P2_SERIAL1_RECEIVE_BIT     4
`define P2_STRAP_BIT    6
`define P2_CLKOUT_BIT   7

// Status register bit positions
`define ST_EMU_BIT      0
`define ST_EXTACC_BIT   1
`define ST_NMI_BIT      2

// Reset values
`define RST_BYTE        8'h00
`define RST_WORD        32'h0000_0000

// State time in clocks
`define STATE_CLKS      2

`endif

// ===== design/sync2.v
`timescale 1ns/10ps
module sync2 #(
	parameter W = 1
)(
	// Clock and reset
	input  wire         pclk,
	input  wire         presetn,
	input  wire         ce,
	// Data
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);

reg [W-1:0] meta_r;

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		meta_r <= {W{1'b0}};
		q      <= {W{1'b0}};
	end
	else if (ce)
	begin
		meta_r <= d;
		q      <= meta_r;
	end
end

endmodule

// ===== verification/pin_mux_checker.sv
`timescale 1ns/10ps
module pin_mux_checker (
	// Clock and reset
	input logic        pclk,
	input logic        presetn,
	// Register bus
	input logic        pslverr,
	// Core bus status
	input logic        bus_cycle_active,
	input logic        bus_cycle_fetch,
	input logic        bus_cycle_internal,
	input logic        bus_addr_data_low,
	input logic        bus_addr_data_high,
	input logic [15:0] bus_ad_out,
	input logic        bus_ad_drive,
	// Interrupt and straps
	input logic        nmi_pin,
	input logic        nmi_event,
	input logic        irq_grant_nmi,
	input logic        irq_grant_other,
	input logic        onchip_emulation_mode,
	input logic        external_access_latched_n,
	// Pins
	input logic        instr_fetch_flag,
	input logic        instr_fetch_flag_oe,
	input logic [7:0]  port_two_pins_oe,
	input logic [7:0]  port_three_pins_oe,
	input logic [7:0]  port_three_pins_out,
	input logic [7:0]  port_four_pins_oe,
	input logic [7:0]  port_four_pins_out,
	input logic [7:0]  port_nine_pins_oe
);
	wire [31:0] oe_all = {port_nine_pins_oe, port_four_pins_oe, port_three_pins_oe,
		port_two_pins_oe};
	wire        fetch_ext = bus_cycle_active & bus_cycle_fetch & ~bus_cycle_internal;
	wire        run = ~onchip_emulation_mode;
	wire [7:0]  ad_lo = bus_ad_out[7:0];
	wire [7:0]  ad_hi = bus_ad_out[15:8];

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////
	property p_fetch_hi; fetch_ext |=> instr_fetch_flag; endproperty
	a_fetch_hi: assert property (p_fetch_hi) else $error("flag low in fetch");
	property p_data_lo; bus_cycle_active && !bus_cycle_fetch |=> !instr_fetch_flag; endproperty
	a_data_lo: assert property (p_data_lo) else $error("flag high in data");
	property p_int_lo; bus_cycle_internal |=> !instr_fetch_flag; endproperty
	a_int_lo: assert property (p_int_lo) else $error("flag high internal");
	property p_idle_lo; !bus_cycle_active |=> !instr_fetch_flag; endproperty
	a_idle_lo: assert property (p_idle_lo) else $error("flag high idle");
	property p_nmi; ($rose(nmi_pin) && run) ##1 nmi_pin[*3] |-> ##[0:6] nmi_event; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi edge missed");
	property p_nmi_emu; onchip_emulation_mode |-> !nmi_event; endproperty
	a_nmi_emu: assert property (p_nmi_emu) else $error("nmi in emulation");
	property p_grant; nmi_event |=> irq_grant_nmi && !irq_grant_other; endproperty
	a_grant: assert property (p_grant) else $error("nmi not first");
	property p_emu_oe; onchip_emulation_mode |=> oe_all == 32'h0 && !instr_fetch_flag_oe;
	endproperty
	a_emu_oe: assert property (p_emu_oe) else $error("pin driven in emulation");
	property p_emu_hold; onchip_emulation_mode |=> onchip_emulation_mode; endproperty
	a_emu_hold: assert property (p_emu_hold) else $error("emulation left");
	property p_strap; $past(presetn, 2) && $past(presetn) |->
		$stable(external_access_latched_n) && $stable(onchip_emulation_mode); endproperty
	a_strap: assert property (p_strap) else $error("strap changed");
	property p_ad_lo; $past(presetn) && run && bus_addr_data_low && bus_ad_drive |=>
		port_three_pins_oe == 8'hFF && port_three_pins_out == $past(ad_lo); endproperty
	a_ad_lo: assert property (p_ad_lo) else $error("low bus byte wrong");
	property p_ad_hi; $past(presetn) && run && bus_addr_data_high && bus_ad_drive |=>
		port_four_pins_oe == 8'hFF && port_four_pins_out == $past(ad_hi); endproperty
	a_ad_hi: assert property (p_ad_hi) else $error("high bus byte wrong");

	////////////////////////////////////////////////////////////////////////
	c_fetch: cover property (instr_fetch_flag);
	c_nmi: cover property (nmi_event);
	c_emu: cover property (onchip_emulation_mode);
	c_err: cover property (pslverr);
endmodule

bind fetch_flag_nmi_emulation_ports pin_mux_checker u_pin_mux_checker (.pclk, .presetn,
	.pslverr, .bus_cycle_active, .bus_cycle_fetch, .bus_cycle_internal, .bus_addr_data_low,
	.bus_addr_data_high, .bus_ad_out, .bus_ad_drive, .nmi_pin, .nmi_event, .irq_grant_nmi,
	.irq_grant_other, .onchip_emulation_mode, .external_access_latched_n, .instr_fetch_flag,
	.instr_fetch_flag_oe, .port_two_pins_oe, .port_three_pins_oe, .port_three_pins_out,
	.port_four_pins_oe, .port_four_pins_out, .port_nine_pins_oe);

// ===== verification/pin_partner.sv
`timescale 1ns/10ps
module pin_partner (
	// Clock
	input logic         pclk,
	// Interrupt request
	input logic         nmi_go,
	output logic        nmi_pin,
	// Pin levels
	input logic [31:0]  oe_all,
	input logic [31:0]  out_all,
	input logic [31:0]  far_drv,
	output logic [31:0] pins_in
);
	int hold_cnt = 0;

	// Released pins show the far-side level, idle high
	assign pins_in = (oe_all & out_all) | (~oe_all & far_drv);
	// Interrupt held over three state times
	assign nmi_pin = hold_cnt != 0;
	always @(posedge pclk)
		hold_cnt <= nmi_go ? 6 : (hold_cnt != 0 ? hold_cnt - 1 : 0);
endmodule

// ===== verification/fetch_flag_nmi_emulation_ports_tb.sv
`timescale 1ns/10ps
`include "pin_mux_consts.vh"
module fetch_flag_nmi_emulation_ports_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, nmi_event, mode, ext_lat, fflag_oe, nmi_pin;
	logic        emu_n = 1'b1, pll = 1'b1, ext_n = 1'b0, nmi_go = 1'b0, ad_sel = 1'b0;
	logic [63:0] rnd = 64'h0;
	logic [31:0] far_drv = 32'hFFFF_FFFF;
	logic        ser0_rx, ser1_rx, ext_irq;
	logic [15:0] ad_in;
	wire [31:0]  oe_all, out_all, pins_in;
	integer      seed = 76557;
	int          err_total = 0, compares = 0;
	logic [32:0] expq[$];

	always #5 pclk = ~pclk;
	always @(posedge pclk) rnd <= {$random(seed), $random(seed)};

	fetch_flag_nmi_emulation_ports u_fetch_flag_nmi_emulation_ports (.pclk, .presetn,
		.ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.emulation_isolate_strap_n(emu_n), .pll_enable_strap(pll),
		.external_access_strap_n(ext_n), .nmi_pin, .bus_cycle_active(rnd[0]),
		.bus_cycle_fetch(rnd[1]), .bus_cycle_internal(rnd[2]), .bus_addr_data_low(ad_sel),
		.bus_addr_data_high(ad_sel), .bus_ad_out(rnd[18:3]), .bus_ad_drive(rnd[19]),
		.other_irq_req(rnd[20]), .serial0_transmit(rnd[21]), .serial1_transmit(rnd[22]),
		.clkout_func(rnd[23]), .compare_only_outputs(rnd[31:24]), .serial0_receive(ser0_rx),
		.serial1_receive(ser1_rx), .external_irq_in(ext_irq), .bus_ad_in(ad_in), .nmi_event,
		.irq_grant_nmi(), .irq_grant_other(), .onchip_emulation_mode(mode),
		.external_access_latched_n(ext_lat), .instr_fetch_flag(), .instr_fetch_flag_oe(fflag_oe),
		.port_two_pins_in(pins_in[7:0]), .port_two_pins_out(out_all[7:0]),
		.port_two_pins_oe(oe_all[7:0]), .port_three_pins_in(pins_in[15:8]),
		.port_three_pins_out(out_all[15:8]), .port_three_pins_oe(oe_all[15:8]),
		.port_four_pins_in(pins_in[23:16]), .port_four_pins_out(out_all[23:16]),
		.port_four_pins_oe(oe_all[23:16]), .port_nine_pins_in(pins_in[31:24]),
		.port_nine_pins_out(out_all[31:24]), .port_nine_pins_oe(oe_all[31:24]));

	pin_partner u_pin_partner (.pclk, .nmi_go, .nmi_pin, .oe_all, .out_all, .far_drv,
		.pins_in);

	////////////////////////////////////////////////////////////////////////
	task check(input string nm, input [32:0] seen, input [32:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task end_sim;
		$display("Mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task apb(input w, input [11:0] a, input [31:0] d, input [32:0] e);
		expq.push_back(e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task do_reset(input e_n, input p_n);
		presetn <= 1'b0;
		emu_n <= e_n;
		pll <= p_n;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask

	task pulse_nmi;
		@(posedge pclk);
		nmi_go <= 1'b1;
		@(posedge pclk);
		nmi_go <= 1'b0;
	endtask

	// Completed transfers checked in order
	always @(posedge pclk)
		if (psel && penable && pready)
			check("apb", {pslverr, pwrite ? 32'h0 : prdata}, expq.pop_front());

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		int n;
		logic [2:0] tx_exp;
		logic [7:0] p9_exp;
		logic [31:0] v[12];
		logic [11:0] ca[8] = '{`REG_P2_SEL, `REG_P2_DIR, `REG_P3_DIR, `REG_P3_OD, `REG_P3_OUT,
			`REG_P4_OD, `REG_P4_DIR, `REG_P4_OUT};
		logic [7:0] cd[8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h0F, 8'h00, 8'hFF, 8'hA5};
		do_reset(1'b1, 1'b1);
		ext_n <= 1'b1;
		repeat (3) @(posedge pclk);
		check("ext_lat", ext_lat, 33'h0);
		check("emu", mode, 33'h0);
		for (int i = 0; i < 12; i++)
		begin
			v[i] = $random(seed);
			apb(1'b1, 12'(i * 4), v[i], 33'h0);
		end
		for (int i = 0; i < 12; i++)
			apb(1'b0, 12'(i * 4), 32'h0, {25'h0, v[i][7:0]});
		apb(1'b1, 12'h03C, 32'hFFFF_FFFF, 33'h1_0000_0000);
		apb(1'b0, 12'h03C, 32'h0, 33'h1_0000_0000);
		for (int i = 0; i < 8; i++)
			apb(1'b1, ca[i], {24'h0, cd[i]}, 33'h0);
		repeat (3) @(posedge pclk);
		check("p3 oe", oe_all[15:8], 33'hF0);
		check("p3 out", out_all[15:8], 33'h00);
		check("p4 oe", oe_all[23:16], 33'hFF);
		check("p4 out", out_all[23:16], 33'hA5);
		check("p9 oe", oe_all[31:24], {25'h0, v[11][7:0] | v[10][7:0]});
		apb(1'b0, `REG_PIN_IN, 32'h0, {9'h000, 8'hA5, 8'h0F, 8'hFF});
		check("ad in", ad_in, 33'hA50F);
		apb(1'b1, `REG_P2_SEL, 32'h0000_009F, 33'h0);
		far_drv[7:0] <= 8'hED;
		repeat (5) @(posedge pclk);
		check("p2 oe", oe_all[7:0], 33'h89);
		check("rx", {ser0_rx, ser1_rx, ext_irq}, 33'h1);
		for (int i = 0; i < 8; i++)
		begin
			tx_exp = {rnd[23], rnd[22], rnd[21]};
			p9_exp = (v[11][7:0] & rnd[31:24]) | (~v[11][7:0] & v[9][7:0]);
			@(posedge pclk);
			check("p2 fn", {out_all[7], out_all[3], out_all[0]}, tx_exp);
			check("p9 fn", out_all[31:24], p9_exp);
		end
		ad_sel <= 1'b1;
		repeat (30) @(posedge pclk);
		ad_sel <= 1'b0;
		pulse_nmi();
		n = 0;
		while (nmi_event !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		check("nmi", nmi_event, 33'h1);
		do_reset(1'b0, 1'b0);
		check("emu", mode, 33'h1);
		check("oe", {fflag_oe, oe_all}, 33'h0);
		apb(1'b0, `REG_STATUS, 32'h0, 33'h3);
		pulse_nmi();
		repeat (20) @(posedge pclk);
		check("emu", mode, 33'h1);
		do_reset(1'b0, 1'b1);
		check("emu", mode, 33'h0);
		end_sim();
	end

	initial
	begin
		#100000;
		err_total++;
		end_sim();
	end
endmodule
